// *** src/bpcfg_params.svh ***
// Register offsets, field positions and timing constants of the backplane config block
`ifndef BPCFG_PARAMS_SVH
`define BPCFG_PARAMS_SVH

// Register byte addresses on the local processor port
`define ADDR_SYSCFG      32'h1008_0000
`define ADDR_ERRSTAT     32'h1008_0004
`define ADDR_PAGEADDR    32'h1008_0008

// System configuration fields
`define CFG_POWER_GOOD   15
`define CFG_HALT_EN      14
`define CFG_LOSS_ACT     7
`define CFG_DB_HI        3
`define CFG_DB_LO        1
`define CFG_WMASK        32'h0000_408e
`define CFG_RESET        32'h0000_0000

// Error status fields
`define ST_HALT          15
`define ST_DCNEG         14
`define ST_REPLY_TO      7
`define ST_PARITY        5
`define ST_MEMERR        4
`define ST_LOST          3
`define ST_GRANT_TO      2
`define ST_MISSING       0
`define ST_IMPL_MASK     32'h0000_c0bd
`define ST_CAPTURE_MASK  32'h0000_00b1
`define ST_RESET         32'h0000_0000

// Captured page: backplane address bits 21:9 into bits 12:0
`define PAGE_W           13
`define PAGE_RESET       13'h0000

// Timing, clock at 10 MHz
`define CLK_PERIOD_NS    100
`define REPLY_TIMEOUT_NS 10000
`define GRANT_TIMEOUT_NS 10000000
`define REPLY_TIMEOUT_CYCLES ((`REPLY_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GRANT_TIMEOUT_CYCLES ((`GRANT_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W          17
`define TIMER_ZERO       17'h00000

`endif

// *** src/bpcfg_pkg.sv ***
// Types shared by the backplane config and error log block
package bpcfg_pkg;

  // Local port state, Gray along idle to arbitrate
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARB  = 2'b01
  } bus_state_type;

  // Error timer state, Gray along idle, grant, reply
  typedef enum logic [1:0] {
    T_IDLE  = 2'b00,
    T_GRANT = 2'b01,
    T_REPLY = 2'b11
  } timer_state_type;

  typedef enum logic [1:0] {
    CYC_DEMAND_READ  = 2'b00,
    CYC_DEMAND_WRITE = 2'b01,
    CYC_IACK         = 2'b10,
    CYC_REQUEST_READ = 2'b11
  } cycle_kind_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  byte_en;
  } local_req_type;

  typedef struct packed {
    logic        valid;
    logic        bus_error;
    logic [31:0] rdata;
  } local_resp_type;

  typedef struct packed {
    logic           start;
    cycle_kind_type kind;
    logic [12:0]    page;
    logic           reply;
    logic           parity_error;
  } backplane_cycle_type;

endpackage

// *** src/error_timers.sv ***
// Grant and reply watchdogs for processor demand cycles on the backplane
`timescale 1ns/10ps
`include "bpcfg_params.svh"
module error_timers #(
  parameter int GRANT_TIMEOUT_CYCLES = `GRANT_TIMEOUT_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire bpcfg_pkg::backplane_cycle_type cycle,
  input  wire logic                          bus_grant,
  output logic                               reply_timeout,
  output logic                               grant_timeout,
  output logic                               parity_event,
  output logic [`PAGE_W-1:0]                 page
);
  import bpcfg_pkg::*;

  timer_state_type     state;
  timer_state_type     next_state;
  logic [`TIMER_W-1:0] count;
  logic [`TIMER_W-1:0] next_count;
  logic                is_read;
  logic                next_is_read;
  logic [`PAGE_W-1:0]  next_page;
  logic                next_reply_timeout;
  logic                next_grant_timeout;
  logic                next_parity_event;

  localparam logic [`TIMER_W-1:0] GRANT_LAST = `TIMER_W'(GRANT_TIMEOUT_CYCLES - 1);
  localparam logic [`TIMER_W-1:0] REPLY_LAST = `TIMER_W'(`REPLY_TIMEOUT_CYCLES - 1);

  // Only demand cycles are watched; iack and request reads never start a timer
  always_comb begin
    next_state         = state;
    next_count         = count;
    next_is_read       = is_read;
    next_page          = page;
    next_reply_timeout = 1'b0;
    next_grant_timeout = 1'b0;
    next_parity_event  = 1'b0;
    case (state)
      T_IDLE: begin
        if (cycle.start && (cycle.kind == CYC_DEMAND_READ ||
                            cycle.kind == CYC_DEMAND_WRITE)) begin
          next_state   = T_GRANT;
          next_count   = `TIMER_ZERO;
          next_page    = cycle.page;
          next_is_read = (cycle.kind == CYC_DEMAND_READ);
        end
      end
      T_GRANT: begin
        if (bus_grant) begin
          next_state = T_REPLY;
          next_count = `TIMER_ZERO;
        end else if (count == GRANT_LAST) begin
          next_grant_timeout = 1'b1;
          next_state         = T_IDLE;
        end else begin
          next_count = count + `TIMER_W'(1);
        end
      end
      T_REPLY: begin
        if (cycle.reply) begin
          next_parity_event = cycle.parity_error && is_read;
          next_state        = T_IDLE;
        end else if (count == REPLY_LAST) begin
          next_reply_timeout = 1'b1;
          next_state         = T_IDLE;
        end else begin
          next_count = count + `TIMER_W'(1);
        end
      end
      default: next_state = T_IDLE;
    endcase
  end

  // Timer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state         <= T_IDLE;
      count         <= `TIMER_ZERO;
      is_read       <= 1'b0;
      page          <= `PAGE_RESET;
      reply_timeout <= 1'b0;
      grant_timeout <= 1'b0;
      parity_event  <= 1'b0;
    end else begin
      state         <= next_state;
      count         <= next_count;
      is_read       <= next_is_read;
      page          <= next_page;
      reply_timeout <= next_reply_timeout;
      grant_timeout <= next_grant_timeout;
      parity_event  <= next_parity_event;
    end
  end

endmodule

// *** src/backplane_config_error_log.sv ***
// Backplane interface configuration, error status and error page address registers
//
// Summary of operation
// - Power-good flag bit 15 follows synchronised backplane power-good; writes ignored.
// - Halt enable set: backplane halt halts processor and sets status bit 15.
// - Loss action bit clear: DC-good negation asserts board hard reset.
// - Loss action bit set: DC-good negation asserts halt request input.
// - Configuration fields clear at power up and DC-good loss with bit 7 clear.
// - Doorbell select zero in auxiliary mode blocks all doorbell register access.
// - Processor configuration write waits for backplane grant before updating.
// - Configuration takes byte lanes; bits 31:16 and 0 read zero.
// - Status bits set on event; write one clears, write zero keeps.
// - Status clears at power up, DC-good loss with bit 7 clear, I/O reset write.
// - Status bit 15 sets on backplane halt while halt enable set.
// - Status bit 14 sets on DC-good negation while loss action bit set.
// - Status bit 7 sets on demand cycle with no reply in 10 us.
// - Status bit 5 sets on demand read returning parity error.
// - Status bit 4 sets on local memory read error; reported to doorbell register.
// - Status bit 3 sets when capturing error arrives with any of bits 7,5,4,0 set.
// - Status bit 2 sets when grant for demand cycle misses 10 ms.
// - Status bit 0 sets on DMA to missing main memory.
// - Page address register meaningful only while status bit 5 or 7 set.
// - Captured page holds backplane address 21:9 in bits 12:0; rest zero.
// - Later parity or reply timeout errors set lost bit, keep captured page.
// - Page register read-only, longword only; writes answer with bus error.
// - Doorbell register memory error flag clears whenever status bit 4 clears.
`timescale 1ns/10ps
`include "bpcfg_params.svh"
module backplane_config_error_log #(
  parameter int GRANT_TIMEOUT_CYCLES = `GRANT_TIMEOUT_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire bpcfg_pkg::local_req_type      req,
  output logic                               req_ready,
  output bpcfg_pkg::local_resp_type          resp,
  input  wire bpcfg_pkg::backplane_cycle_type cycle,
  input  wire logic                          bus_grant,
  output logic                               bus_request,
  input  wire logic                          dma_mem_error,
  input  wire logic                          dma_missing_memory,
  input  wire logic                          io_reset_register_write,
  input  wire logic                          aux_mode,
  input  wire logic                          backplane_halt_line,
  input  wire logic                          backplane_power_good,
  input  wire logic                          dc_good_signal,
  output logic                               cpu_halt,
  output logic                               board_hard_reset,
  output logic                               halt_request_input,
  output logic [2:0]                         doorbell_select,
  output logic                               doorbell_access_block,
  output logic                               ipc_mem_error_set,
  output logic                               ipc_mem_error_clear
);
  import bpcfg_pkg::*;

  // Byte enables widened into a bit mask; used for both writable registers
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Two-stage synchronisers for the asynchronous backplane levels
  logic [2:0] async_in;
  logic [2:0] sync_meta;
  logic [2:0] sync_out;

  assign async_in = {dc_good_signal, backplane_power_good, backplane_halt_line};

  generate
    for (genvar g = 0; g < 3; g++) begin : gen_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          sync_meta[g] <= 1'b0;
          sync_out[g]  <= 1'b0;
        end else begin
          sync_meta[g] <= async_in[g];
          sync_out[g]  <= sync_meta[g];
        end
      end
    end
  endgenerate

  logic halt_sync;
  logic pok_sync;
  logic dc_sync;
  logic dc_prev;
  logic dc_negated;

  assign halt_sync = sync_out[0];
  assign pok_sync  = sync_out[1];
  assign dc_sync   = sync_out[2];

  // Watchdogs on processor demand cycles
  logic               reply_timeout;
  logic               grant_timeout;
  logic               parity_event;
  logic [`PAGE_W-1:0] timer_page;

  error_timers #(
    .GRANT_TIMEOUT_CYCLES (GRANT_TIMEOUT_CYCLES)
  ) u_timers (
    .clk           (clk),
    .rst           (rst),
    .cycle         (cycle),
    .bus_grant     (bus_grant),
    .reply_timeout (reply_timeout),
    .grant_timeout (grant_timeout),
    .parity_event  (parity_event),
    .page          (timer_page)
  );

  // Register state and next values
  bus_state_type      state;
  bus_state_type      next_state;
  local_req_type      held;
  local_req_type      next_held;
  local_resp_type     next_resp;
  logic [31:0]        cfg;
  logic [31:0]        next_cfg;
  logic               power_flag;
  logic               next_power_flag;
  logic [31:0]        status;
  logic [31:0]        next_status;
  logic [`PAGE_W-1:0] page;
  logic [`PAGE_W-1:0] next_page;
  logic               next_cpu_halt;
  logic               next_board_hard_reset;
  logic               next_halt_request_input;
  logic               next_ipc_set;
  logic               next_ipc_clear;

  logic        take;
  logic        soft_clear;
  logic [31:0] status_set;
  logic [31:0] status_clr;
  logic        capture_event;
  logic [31:0] cfg_mask;

  // Loss of DC-good with the action bit clear acts like a power-up clear
  assign dc_negated = dc_prev && !dc_sync;
  assign soft_clear = dc_negated && !cfg[`CFG_LOSS_ACT];

  // Handshake outputs
  assign req_ready   = (state == ST_IDLE);
  assign take        = req.valid && req_ready;
  assign bus_request = (state == ST_ARB);

  // Doorbell select only matters in auxiliary configuration
  assign doorbell_select       = cfg[`CFG_DB_HI:`CFG_DB_LO];
  assign doorbell_access_block = aux_mode && (cfg[`CFG_DB_HI:`CFG_DB_LO] == 3'h0);

  // Local port: configuration writes arbitrate; everything else answers at once
  always_comb begin
    next_state      = state;
    next_held       = held;
    next_resp       = '0;
    next_cfg        = cfg;
    next_power_flag = pok_sync;
    status_clr      = 32'h0000_0000;
    cfg_mask        = lane_mask(held.byte_en) & `CFG_WMASK;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_held = req;
          if (req.addr == `ADDR_SYSCFG) begin
            if (req.write) begin
              next_state = ST_ARB;
            end else begin
              next_resp.valid = 1'b1;
              next_resp.rdata = (cfg & `CFG_WMASK) |
                                (32'(power_flag) << `CFG_POWER_GOOD);
            end
          end else if (req.addr == `ADDR_ERRSTAT) begin
            next_resp.valid = 1'b1;
            if (req.write) begin
              status_clr = req.wdata & lane_mask(req.byte_en) & `ST_IMPL_MASK;
            end else begin
              next_resp.rdata = status;
            end
          end else if (req.addr == `ADDR_PAGEADDR) begin
            next_resp.valid = 1'b1;
            if (req.write || req.byte_en != 4'hf) begin
              next_resp.bus_error = 1'b1;
            end else begin
              next_resp.rdata = {19'h0, page};
            end
          end else begin
            next_resp.valid     = 1'b1;
            next_resp.bus_error = 1'b1;
          end
        end
      end
      ST_ARB: begin
        if (bus_grant) begin
          next_cfg        = (cfg & ~cfg_mask) | (held.wdata & cfg_mask);
          next_resp.valid = 1'b1;
          next_state      = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (soft_clear) begin
      next_cfg        = `CFG_RESET;
      next_power_flag = 1'b0;
    end
  end

  // Error status: hardware set wins over a software clear in the same cycle
  always_comb begin
    capture_event = reply_timeout || parity_event || dma_mem_error || dma_missing_memory;
    status_set               = 32'h0000_0000;
    status_set[`ST_HALT]     = cfg[`CFG_HALT_EN] && halt_sync;
    status_set[`ST_DCNEG]    = dc_negated && cfg[`CFG_LOSS_ACT];
    status_set[`ST_REPLY_TO] = reply_timeout;
    status_set[`ST_PARITY]   = parity_event;
    status_set[`ST_MEMERR]   = dma_mem_error;
    status_set[`ST_LOST]     = capture_event && ((status & `ST_CAPTURE_MASK) != 32'h0);
    status_set[`ST_GRANT_TO] = grant_timeout;
    status_set[`ST_MISSING]  = dma_missing_memory;
    next_status = (status & ~status_clr) | status_set;
    if (soft_clear || io_reset_register_write) begin
      next_status = `ST_RESET;
    end
    // First parity or reply timeout holds the page; later ones only mark the loss
    next_page = page;
    if ((reply_timeout || parity_event) &&
        !status[`ST_REPLY_TO] && !status[`ST_PARITY]) begin
      next_page = timer_page;
    end
    next_ipc_set   = dma_mem_error;
    next_ipc_clear = status[`ST_MEMERR] && !next_status[`ST_MEMERR];
  end

  // Halt and power-loss actions toward the processor board
  always_comb begin
    next_cpu_halt           = cfg[`CFG_HALT_EN] && halt_sync;
    next_board_hard_reset   = board_hard_reset;
    next_halt_request_input = halt_request_input;
    if (dc_negated && !cfg[`CFG_LOSS_ACT]) begin
      next_board_hard_reset = 1'b1;
    end else if (dc_negated) begin
      next_halt_request_input = 1'b1;
    end else if (dc_sync) begin
      // Held until DC-good returns so the board sees a full reset window
      next_board_hard_reset   = 1'b0;
      next_halt_request_input = 1'b0;
    end
  end

  // All block registers except the synchroniser stages and the watchdog timers
  always_ff @(posedge clk) begin
    if (rst) begin
      state              <= ST_IDLE;
      held               <= '0;
      resp               <= '0;
      cfg                <= `CFG_RESET;
      power_flag         <= 1'b0;
      status             <= `ST_RESET;
      page               <= `PAGE_RESET;
      dc_prev            <= 1'b0;
      cpu_halt           <= 1'b0;
      board_hard_reset   <= 1'b0;
      halt_request_input <= 1'b0;
      ipc_mem_error_set  <= 1'b0;
      ipc_mem_error_clear <= 1'b0;
    end else begin
      state              <= next_state;
      held               <= next_held;
      resp               <= next_resp;
      cfg                <= next_cfg;
      power_flag         <= next_power_flag;
      status             <= next_status;
      page               <= next_page;
      dc_prev            <= dc_sync;
      cpu_halt           <= next_cpu_halt;
      board_hard_reset   <= next_board_hard_reset;
      halt_request_input <= next_halt_request_input;
      ipc_mem_error_set  <= next_ipc_set;
      ipc_mem_error_clear <= next_ipc_clear;
    end
  end

endmodule

// *** verif/bpcfg_monitor.sv ***
// Port assertions for the backplane config and error log block
`timescale 1ns/10ps
`include "bpcfg_params.svh"
module bpcfg_monitor #(
  parameter int GRANT_TIMEOUT_CYCLES = `GRANT_TIMEOUT_CYCLES
) (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire bpcfg_pkg::local_req_type  req,
  input wire logic                      req_ready,
  input wire bpcfg_pkg::local_resp_type resp,
  input wire logic                      bus_grant,
  input wire logic                      bus_request,
  input wire logic                      dma_mem_error,
  input wire logic                      aux_mode,
  input wire logic                      backplane_halt_line,
  input wire logic                      dc_good_signal,
  input wire logic                      cpu_halt,
  input wire logic                      board_hard_reset,
  input wire logic                      halt_request_input,
  input wire logic [2:0]                doorbell_select,
  input wire logic                      doorbell_access_block,
  input wire logic                      ipc_mem_error_set
);
  import bpcfg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic take_rd;
  logic take_wr;
  // Requests taken on this edge
  assign take_rd = req.valid && req_ready && !req.write;
  assign take_wr = req.valid && req_ready && req.write;
  AST_CFG_WAIT: assert property (bus_request && !bus_grant |=> bus_request && !resp.valid)
    else $error("config write left arbitration without a grant");
  AST_CFG_DONE: assert property (bus_request && bus_grant |=> resp.valid && req_ready)
    else $error("config write not answered after grant");
  AST_CFG_LOCK: assert property (bus_request |-> !req_ready)
    else $error("port ready while config write arbitrates");
  AST_READ_ANSWER: assert property (take_rd |=> resp.valid ##1 !resp.valid)
    else $error("read answer not a one cycle pulse");
  AST_CFG_ZERO: assert property (take_rd && req.addr == `ADDR_SYSCFG |=>
    resp.rdata[31:16] == 16'h0 && resp.rdata[6:4] == 3'h0 && !resp.rdata[0])
    else $error("unused config bits read non-zero");
  AST_PAGE_ZERO: assert property (take_rd && req.addr == `ADDR_PAGEADDR |=>
    resp.rdata[31:13] == 19'h0)
    else $error("page register upper bits non-zero");
  AST_PAGE_RO: assert property (take_wr && req.addr == `ADDR_PAGEADDR |=>
    resp.valid && resp.bus_error)
    else $error("page register write not refused");
  AST_HALT_OFF: assert property (!backplane_halt_line [*4] |-> !cpu_halt)
    else $error("processor halted without halt line");
  AST_DC_ACTION: assert property ($fell(dc_good_signal) ##1 !dc_good_signal [*4] |->
    board_hard_reset || halt_request_input)
    else $error("no action on dc good loss");
  AST_IPC_SET: assert property (dma_mem_error |=> ipc_mem_error_set)
    else $error("memory error not passed on");
  AST_IPC_CAUSE: assert property (ipc_mem_error_set |-> $past(dma_mem_error))
    else $error("memory error flag without cause");
  AST_DB_BLOCK: assert property (doorbell_access_block ==
    (aux_mode && doorbell_select == 3'h0))
    else $error("doorbell block wrong");
endmodule

bind backplane_config_error_log bpcfg_monitor #(.GRANT_TIMEOUT_CYCLES(GRANT_TIMEOUT_CYCLES))
  bpcfg_monitor_i (.clk, .rst, .req, .req_ready, .resp, .bus_grant, .bus_request,
  .dma_mem_error, .aux_mode, .backplane_halt_line, .dc_good_signal, .cpu_halt,
  .board_hard_reset, .halt_request_input, .doorbell_select, .doorbell_access_block,
  .ipc_mem_error_set);

// *** verif/backplane_partner.sv ***
// Far-side model: backplane arbiter and slaves answering demand cycles
`timescale 1ns/10ps
module backplane_partner (
  input  wire logic                    clk,
  input  wire logic                    bus_request,
  output bpcfg_pkg::backplane_cycle_type cycle,
  output logic                         bus_grant
);
  import bpcfg_pkg::*;
  int   arb_wait = 3;
  int   n = 0;
  logic arb_grant = 1'b0;
  logic dem_grant = 1'b0;
  initial cycle = '0;
  assign bus_grant = arb_grant | dem_grant;
  // Slow arbiter; grant drops once the request is withdrawn
  always @(negedge clk) begin
    n = bus_request ? n + 1 : 0;
    arb_grant = bus_request && n > arb_wait;
  end
  // One demand cycle; a negative wait means no grant or no reply
  task automatic demand(input cycle_kind_type k, input logic [12:0] pg,
                        input int gw, input int rw, input logic par);
    @(negedge clk);
    cycle = '{1'b1, k, pg, 1'b0, 1'b0};
    @(negedge clk);
    cycle.start = 1'b0;
    cycle.page = ~pg; // Address is not held after start
    repeat (gw < 0 ? 30 : gw) @(negedge clk);
    if (gw >= 0) begin
      dem_grant = 1'b1;
      repeat (rw < 0 ? 110 : rw) @(negedge clk);
      cycle.reply = rw >= 0;
      cycle.parity_error = par && rw >= 0;
      @(negedge clk);
      cycle.reply = 1'b0;
      cycle.parity_error = 1'b0;
      dem_grant = 1'b0;
    end
    repeat (3) @(negedge clk);
  endtask
endmodule

// *** verif/backplane_config_error_log_bench.sv ***
// Self-checking bench for the backplane config and error log block
`timescale 1ns/10ps
`include "bpcfg_params.svh"
module backplane_config_error_log_bench;
  import bpcfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  local_req_type       req = '0;
  local_resp_type      resp;
  backplane_cycle_type cycle;
  logic req_ready, bus_grant, bus_request, cpu_halt, board_hard_reset, halt_request_input;
  logic [2:0] doorbell_select;
  logic doorbell_access_block, ipc_mem_error_set, ipc_mem_error_clear;
  logic dma_mem_error = 1'b0, dma_missing_memory = 1'b0, io_reset_register_write = 1'b0;
  logic aux_mode = 1'b0, backplane_halt_line = 1'b0;
  logic backplane_power_good = 1'b1, dc_good_signal = 1'b1;
  int   num_errors = 0;
  int   checks_done = 0;
  logic [31:0] v;
  logic b;
  logic hit = 1'b0;

  // Short grant watchdog keeps the run brief
  backplane_config_error_log #(.GRANT_TIMEOUT_CYCLES(20)) backplane_config_error_log_i (
    .clk, .rst, .req, .req_ready, .resp, .cycle, .bus_grant, .bus_request, .dma_mem_error,
    .dma_missing_memory, .io_reset_register_write, .aux_mode, .backplane_halt_line,
    .backplane_power_good, .dc_good_signal, .cpu_halt, .board_hard_reset,
    .halt_request_input, .doorbell_select, .doorbell_access_block, .ipc_mem_error_set,
    .ipc_mem_error_clear);
  backplane_partner backplane_partner_i (.clk, .bus_request, .cycle, .bus_grant);

  initial forever #50 clk = ~clk;

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, s, e);
    end
  endtask

  // Register access; request held until taken, released at the next falling edge
  task automatic acc(input logic w, input logic [31:0] a, d, input logic [3:0] be);
    int k;
    req = '{1'b1, w, a, d, be};
    for (k = 0; k < 300 && req_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    req.valid = 1'b0;
    for (k = 0; k < 300 && resp.valid !== 1'b1; k++) @(negedge clk);
    chk(32'(resp.valid), 32'h1);
    v = resp.rdata;
    b = resp.bus_error;
    @(negedge clk);
  endtask

  task automatic rdm(input logic [31:0] a, m, e);
    acc(1'b0, a, 32'h0, 4'hf);
    chk(v & m, e);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  // Writable bits, byte lanes, power flag and refused accesses
  task automatic t_cfg;
    rdm(`ADDR_SYSCFG, 32'hffffffff, 32'h00008000);
    backplane_partner_i.arb_wait = 6;
    acc(1'b1, `ADDR_SYSCFG, 32'hffffffff, 4'hf);
    rdm(`ADDR_SYSCFG, 32'hffffffff, 32'h0000c08e);
    acc(1'b1, `ADDR_SYSCFG, 32'h0, 4'h2);
    rdm(`ADDR_SYSCFG, 32'hffffffff, 32'h0000808e);
    backplane_power_good = 1'b0;
    repeat (4) @(negedge clk);
    acc(1'b1, `ADDR_SYSCFG, 32'h00008000, 4'hf);
    rdm(`ADDR_SYSCFG, 32'hffffffff, 32'h0);
    backplane_power_good = 1'b1;
    acc(1'b1, `ADDR_PAGEADDR, 32'h1, 4'hf);
    chk(32'(b), 32'h1);
    acc(1'b0, `ADDR_PAGEADDR, 32'h0, 4'h1);
    chk(32'(b), 32'h1);
  endtask

  // Zero select blocks the doorbell in auxiliary mode; select 5 lifts the block
  task automatic t_db;
    aux_mode = 1'b1;
    @(negedge clk);
    chk(32'(doorbell_access_block), 32'h1);
    acc(1'b1, `ADDR_SYSCFG, 32'h0000000a, 4'h1);
    chk(32'(doorbell_select), 32'h5);
    chk(32'(doorbell_access_block), 32'h0);
    aux_mode = 1'b0;
  endtask

  // Halt line ignored until enabled; status bit is write-one-to-clear
  task automatic t_halt;
    backplane_halt_line = 1'b1;
    repeat (5) @(negedge clk);
    chk(32'(cpu_halt), 32'h0);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h0);
    acc(1'b1, `ADDR_SYSCFG, 32'h4000, 4'h2);
    repeat (3) @(negedge clk);
    chk(32'(cpu_halt), 32'h1);
    backplane_halt_line = 1'b0;
    repeat (4) @(negedge clk);
    acc(1'b1, `ADDR_ERRSTAT, 32'h0, 4'hf);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h8000);
    acc(1'b1, `ADDR_ERRSTAT, 32'h8000, 4'h2);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h0);
    acc(1'b1, `ADDR_SYSCFG, 32'h0, 4'h2);
  endtask

  // Parity, reply and grant timeouts, page capture and lost errors
  task automatic t_dem;
    backplane_partner_i.demand(CYC_DEMAND_READ, 13'h1a5, 2, 3, 1'b1);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h0020);
    rdm(`ADDR_PAGEADDR, 32'hffffffff, 32'h000001a5);
    backplane_partner_i.demand(CYC_DEMAND_WRITE, 13'h0f0f, 1, -1, 1'b0);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h00a8);
    rdm(`ADDR_PAGEADDR, 32'hffffffff, 32'h000001a5);
    acc(1'b1, `ADDR_ERRSTAT, 32'h00a8, 4'h1);
    backplane_partner_i.demand(CYC_IACK, 13'h3, 1, -1, 1'b1);
    backplane_partner_i.demand(CYC_REQUEST_READ, 13'h4, 1, 2, 1'b1);
    backplane_partner_i.demand(CYC_REQUEST_READ, 13'h5, -1, 0, 1'b0);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h0);
    backplane_partner_i.demand(CYC_DEMAND_READ, 13'h6, -1, 0, 1'b0);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h0004);
    acc(1'b1, `ADDR_ERRSTAT, 32'h4, 4'h1);
  endtask

  // Memory errors, doorbell flag set and clear, I/O reset
  task automatic t_dma;
    dma_mem_error = 1'b1;
    @(negedge clk);
    dma_mem_error = 1'b0;
    chk(32'(ipc_mem_error_set), 32'h1);
    pulse(dma_missing_memory);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h0019);
    fork
      acc(1'b1, `ADDR_ERRSTAT, 32'h10, 4'h1);
      repeat (4) @(negedge clk) hit |= ipc_mem_error_clear;
    join
    chk(32'(hit), 32'h1);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h0009);
    pulse(io_reset_register_write);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h0);
  endtask

  // DC good loss: halt request with bit 7 set, hard reset and clear without
  task automatic t_dc;
    acc(1'b1, `ADDR_SYSCFG, 32'h4080, 4'h3);
    dc_good_signal = 1'b0;
    repeat (5) @(negedge clk);
    chk(32'(halt_request_input), 32'h1);
    chk(32'(board_hard_reset), 32'h0);
    rdm(`ADDR_SYSCFG, 32'h7fff, 32'h4080);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h4000);
    dc_good_signal = 1'b1;
    repeat (5) @(negedge clk);
    acc(1'b1, `ADDR_SYSCFG, 32'h0, 4'h1);
    dc_good_signal = 1'b0;
    repeat (5) @(negedge clk);
    chk(32'(board_hard_reset), 32'h1);
    rdm(`ADDR_SYSCFG, 32'h7fff, 32'h0);
    rdm(`ADDR_ERRSTAT, 32'hffff, 32'h0);
    dc_good_signal = 1'b1;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_cfg();
    t_db();
    t_halt();
    t_dem();
    t_dma();
    t_dc();
    print_verdict();
  end

  // Watchdog, well beyond the expected run length
  initial begin
    #1500000;
    num_errors++;
    print_verdict();
  end
endmodule
